// file: logic/nsc_cfg.svh
// constants of the status and read-column command decoder
// assumes inclusion by bare name from the status builder and the top
`ifndef NSC_CFG_SVH
`define NSC_CFG_SVH
`define NSC_OP_STATUS 8'h70
`define NSC_OP_ENH 8'h78
`define NSC_OP_FIXED 8'h71
`define NSC_OP_READMODE 8'h00
`define NSC_OP_CHCOL 8'h05
`define NSC_OP_CONFIRM 8'hE0
`define NSC_ROW_LAST 2'h2
`define NSC_ROW_PLANE 2'h1
`define NSC_COL_LAST 2'h1
`define NSC_PLANE_LSB 0
`define NSC_DIE_BIT 0
`define NSC_SR_RDY 6
`define NSC_SR_ARRAY_READY_FLAG 5
`define NSC_SR_PREVIOUS_OP_ERROR 1
`define NSC_SR_FAIL 0
`define NSC_REG_CTRL 4'h0
`define NSC_REG_STATE 4'h4
`define NSC_REG_COLUMN 4'h8
`define NSC_CTRL_SYNC 0
`define NSC_STATE_DIE 0
`define NSC_STATE_MODE 4
`define NSC_STATE_CMD 8
`define NSC_CTRL_RST 1'h0
`define NSC_PIN_IDLE 12'h300
`endif

// file: logic/nsc_pkg.sv
// types of the status and read-column command decoder
// assumes nothing outside itself
`default_nettype none
package nsc_pkg;
   typedef enum logic [2:0] {
      NSC_MODE_IDLE = 3'h1,
      NSC_MODE_STATUS = 3'h2,
      NSC_MODE_DATA = 3'h4
   } nsc_mode_e;
   typedef enum logic [4:0] {
      NSC_ST_CMD = 5'h01,
      NSC_ST_ROW = 5'h02,
      NSC_ST_FIX = 5'h04,
      NSC_ST_COL = 5'h08,
      NSC_ST_CONF = 5'h10
   } nsc_state_e;
endpackage : nsc_pkg
`default_nettype wire

// file: logic/nsc_stat_if.sv
// selection signals between decoder and status builder
// assumes one clock domain
`default_nettype none
interface nsc_stat_if #(
   parameter int DIE_W = 1,
   parameter int PLANE_W = 2
);
   logic [DIE_W-1:0] die;
   logic [PLANE_W-1:0] plane;
   logic per_plane;
   logic [7:0] status;
   modport dec (output die, output plane, output per_plane, input status);
   modport bld (input die, input plane, input per_plane, output status);
endinterface : nsc_stat_if
`default_nettype wire

// file: logic/nsc_pin_sync.sv
// two-flop synchroniser for the nand bus pins
// assumes pins are asynchronous to clk_i
`default_nettype none
module nsc_pin_sync #(
   parameter int W = 12,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] meta_r;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_r <= RST_VAL;
         sync_o <= RST_VAL;
      end else if (ce_i) begin
         meta_r <= pin_i;
         sync_o <= meta_r;
      end
   end
endmodule : nsc_pin_sync
`default_nettype wire

// file: logic/nsc_status_build.sv
// builds the status byte of the selected die
// assumes per-die flags come from logic on the same clock
`default_nettype none
`include "nsc_cfg.svh"
module nsc_status_build #(
   parameter int NUM_DIES = 2,
   parameter int NUM_PLANES = 4
) (
   nsc_stat_if.bld st,
   input wire logic [NUM_DIES-1:0] rdy_i,
   input wire logic [NUM_DIES-1:0] array_ready_flag_i,
   input wire logic [NUM_DIES*NUM_PLANES-1:0] fail_i,
   input wire logic [NUM_DIES*NUM_PLANES-1:0] previous_op_error_i,
   input wire logic [NUM_PLANES-1:0] plane_act_i
);
   logic [NUM_PLANES-1:0] f;
   logic [NUM_PLANES-1:0] fc;
   always_comb begin
      f = fail_i[st.die*NUM_PLANES +: NUM_PLANES];
      fc = previous_op_error_i[st.die*NUM_PLANES +: NUM_PLANES];
      st.status = 8'h00;
      st.status[`NSC_SR_RDY] = rdy_i[st.die];
      st.status[`NSC_SR_ARRAY_READY_FLAG] = array_ready_flag_i[st.die];
      if (st.per_plane) begin
         st.status[`NSC_SR_FAIL] = f[st.plane];
         st.status[`NSC_SR_PREVIOUS_OP_ERROR] = fc[st.plane];
      end else begin
         st.status[`NSC_SR_FAIL] = |(f & plane_act_i);
         st.status[`NSC_SR_PREVIOUS_OP_ERROR] = |(fc & plane_act_i);
      end
   end
endmodule : nsc_status_build
`default_nettype wire

// file: logic/nsc_top.sv
// status-read and read-column command decoder of a nand target
// assumes asynchronous nand pins, per-die flags and cache data on clk_i,
// and an avalon-mm master on clk_i
//
// The Avalon-MM interface to the registers and the register addresses are this design's own decisions.
`default_nettype none
`include "nsc_cfg.svh"
module nsc_top #(
   parameter int NUM_DIES = 2,
   parameter int NUM_PLANES = 4,
   parameter int DIE_W = 1,
   parameter int PLANE_W = 2,
   parameter int COL_W = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic nand_cle_i,
   input wire logic nand_ale_i,
   input wire logic nand_we_n_i,
   input wire logic nand_re_n_i,
   input wire logic [7:0] nand_dq_i,
   output logic [7:0] nand_dq_o,
   output logic nand_dq_oe_n_o,
   input wire logic [NUM_DIES-1:0] die_rdy_i,
   input wire logic [NUM_DIES-1:0] die_array_ready_flag_i,
   input wire logic [NUM_DIES*NUM_PLANES-1:0] die_fail_i,
   input wire logic [NUM_DIES*NUM_PLANES-1:0] die_previous_op_error_i,
   input wire logic [NUM_PLANES-1:0] plane_act_i,
   input wire logic por_busy_i,
   input wire logic otp_mode_i,
   input wire logic [7:0] cache_data_i,
   output logic cache_rd_o,
   output logic [COL_W-1:0] column_o,
   output logic [NUM_DIES-1:0] die_en_o
);
   // ----------------------------------------
   // pin synchronisation and cycle detection
   // ----------------------------------------
   logic [11:0] pins_s;
   logic we_d_r;
   logic re_d_r;
   logic cle_s;
   logic ale_s;
   logic we_s;
   logic re_s;
   logic [7:0] dq_s;
   logic cmd_stb;
   logic addr_stb;
   logic re_fall;
   logic re_rise;

   nsc_pin_sync #(
      .W(12),
      .RST_VAL(`NSC_PIN_IDLE)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .pin_i({nand_cle_i, nand_ale_i, nand_we_n_i, nand_re_n_i, nand_dq_i}),
      .sync_o(pins_s)
   );

   assign {cle_s, ale_s, we_s, re_s, dq_s} = pins_s;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         we_d_r <= 1'h1;
         re_d_r <= 1'h1;
      end else if (ce_i) begin
         we_d_r <= we_s;
         re_d_r <= re_s;
      end
   end

   assign cmd_stb = ce_i & we_s & ~we_d_r & cle_s & ~ale_s;
   assign addr_stb = ce_i & we_s & ~we_d_r & ale_s & ~cle_s;
   assign re_fall = ce_i & ~re_s & re_d_r;
   assign re_rise = ce_i & re_s & ~re_d_r;

   // ----------------------------------------
   // status byte builder
   // ----------------------------------------
   nsc_stat_if #(
      .DIE_W(DIE_W),
      .PLANE_W(PLANE_W)
   ) stat ();

   nsc_status_build #(
      .NUM_DIES(NUM_DIES),
      .NUM_PLANES(NUM_PLANES)
   ) u_build (
      .st(stat),
      .rdy_i(die_rdy_i),
      .array_ready_flag_i(die_array_ready_flag_i),
      .fail_i(die_fail_i),
      .previous_op_error_i(die_previous_op_error_i),
      .plane_act_i(plane_act_i)
   );

   // ----------------------------------------
   // command decoder
   // ----------------------------------------
   nsc_pkg::nsc_state_e st_r;
   nsc_pkg::nsc_mode_e mode_r;
   logic [1:0] cnt_r;
   logic [DIE_W-1:0] die_r;
   logic [PLANE_W-1:0] plane_r;
   logic [PLANE_W-1:0] plane_tmp_r;
   logic per_plane_r;
   logic [7:0] cmd_r;
   logic [COL_W-1:0] col_r;
   logic [COL_W-1:0] col_tmp_r;
   logic sync_if_r;
   logic sel_rdy;
   logic enh_ok;

   assign sel_rdy = die_rdy_i[die_r];
   assign enh_ok = ~por_busy_i & ~otp_mode_i;

   assign stat.die = die_r;
   assign stat.plane = plane_r;
   assign stat.per_plane = per_plane_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= nsc_pkg::NSC_ST_CMD;
         cnt_r <= 2'h0;
      end else if (cmd_stb) begin
         cnt_r <= 2'h0;
         st_r <= nsc_pkg::NSC_ST_CMD;
         if (dq_s == `NSC_OP_ENH && enh_ok) begin
            st_r <= nsc_pkg::NSC_ST_ROW;
         end else if (dq_s == `NSC_OP_FIXED) begin
            st_r <= nsc_pkg::NSC_ST_FIX;
         end else if (dq_s == `NSC_OP_CHCOL && sel_rdy) begin
            st_r <= nsc_pkg::NSC_ST_COL;
         end
      end else if (addr_stb) begin
         cnt_r <= cnt_r + 2'h1;
         unique case (st_r)
            nsc_pkg::NSC_ST_ROW: begin
               if (cnt_r == `NSC_ROW_LAST) begin
                  st_r <= nsc_pkg::NSC_ST_CMD;
               end
            end
            nsc_pkg::NSC_ST_FIX: begin
               st_r <= nsc_pkg::NSC_ST_CMD;
            end
            nsc_pkg::NSC_ST_COL: begin
               if (cnt_r == `NSC_COL_LAST) begin
                  st_r <= nsc_pkg::NSC_ST_CONF;
               end
            end
            nsc_pkg::NSC_ST_CMD, nsc_pkg::NSC_ST_CONF: begin
               st_r <= nsc_pkg::NSC_ST_CMD;
            end
         endcase
      end
   end

   // die, plane and status flavour selection
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         die_r <= '0;
         plane_r <= '0;
         plane_tmp_r <= '0;
         per_plane_r <= 1'h0;
      end else if (cmd_stb && dq_s == `NSC_OP_STATUS) begin
         per_plane_r <= 1'h0;
      end else if (addr_stb && st_r == nsc_pkg::NSC_ST_ROW) begin
         if (cnt_r == `NSC_ROW_PLANE) begin
            plane_tmp_r <= dq_s[`NSC_PLANE_LSB +: PLANE_W];
         end
         if (cnt_r == `NSC_ROW_LAST) begin
            die_r <= dq_s[`NSC_DIE_BIT +: DIE_W];
            plane_r <= plane_tmp_r;
            per_plane_r <= 1'h1;
         end
      end else if (addr_stb && st_r == nsc_pkg::NSC_ST_FIX) begin
         die_r <= dq_s[`NSC_DIE_BIT +: DIE_W];
         per_plane_r <= 1'h0;
      end
   end

   // output mode of the selected die
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_r <= nsc_pkg::NSC_MODE_IDLE;
         cmd_r <= 8'h00;
      end else if (cmd_stb) begin
         cmd_r <= dq_s;
         if (dq_s == `NSC_OP_STATUS) begin
            mode_r <= nsc_pkg::NSC_MODE_STATUS;
         end else if (dq_s == `NSC_OP_READMODE) begin
            mode_r <= nsc_pkg::NSC_MODE_DATA;
         end else if (dq_s == `NSC_OP_CONFIRM && st_r == nsc_pkg::NSC_ST_CONF) begin
            mode_r <= nsc_pkg::NSC_MODE_DATA;
         end else if (dq_s == `NSC_OP_ENH && !enh_ok) begin
            mode_r <= mode_r;
         end else if (dq_s == `NSC_OP_CHCOL && !sel_rdy) begin
            mode_r <= mode_r;
         end else begin
            mode_r <= nsc_pkg::NSC_MODE_IDLE;
         end
      end else if (addr_stb && st_r == nsc_pkg::NSC_ST_FIX) begin
         mode_r <= nsc_pkg::NSC_MODE_STATUS;
      end else if (addr_stb && st_r == nsc_pkg::NSC_ST_ROW && cnt_r == `NSC_ROW_LAST) begin
         mode_r <= nsc_pkg::NSC_MODE_STATUS;
      end
   end

   // ----------------------------------------
   // column address
   // ----------------------------------------
   logic [COL_W-1:0] col_step;
   assign col_step = sync_if_r ? COL_W'(2) : COL_W'(1);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         col_tmp_r <= '0;
         col_r <= '0;
      end else if (addr_stb && st_r == nsc_pkg::NSC_ST_COL) begin
         if (cnt_r == 2'h0) begin
            col_tmp_r[7:0] <= dq_s;
         end else begin
            col_tmp_r[COL_W-1:8] <= dq_s[COL_W-9:0];
         end
      end else if (cmd_stb && dq_s == `NSC_OP_CONFIRM && st_r == nsc_pkg::NSC_ST_CONF) begin
         col_r <= col_tmp_r;
      end else if (re_rise && mode_r == nsc_pkg::NSC_MODE_DATA) begin
         col_r <= col_r + col_step;
      end
   end

   always_comb begin
      column_o = col_r;
      if (sync_if_r) begin
         column_o[0] = 1'h0;
      end
   end

   // ----------------------------------------
   // data bus drive
   // ----------------------------------------
   logic drive_r;
   logic rd_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drive_r <= 1'h0;
         nand_dq_o <= 8'h00;
         rd_r <= 1'h0;
      end else if (ce_i) begin
         rd_r <= re_rise && mode_r == nsc_pkg::NSC_MODE_DATA;
         if (cmd_stb || addr_stb || re_rise) begin
            drive_r <= 1'h0;
         end else if (re_fall && mode_r == nsc_pkg::NSC_MODE_STATUS) begin
            drive_r <= 1'h1;
            nand_dq_o <= stat.status;
         end else if (re_fall && mode_r == nsc_pkg::NSC_MODE_DATA) begin
            drive_r <= 1'h1;
            nand_dq_o <= cache_data_i;
         end
      end
   end

   assign nand_dq_oe_n_o = ~drive_r;
   assign cache_rd_o = rd_r;

   always_comb begin
      die_en_o = '0;
      if (mode_r != nsc_pkg::NSC_MODE_IDLE) begin
         die_en_o[die_r] = 1'h1;
      end
   end

   // ----------------------------------------
   // avalon-mm register slave
   // ----------------------------------------
   logic ack_r;
   logic req;
   assign req = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = req & ~ack_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'h0;
         sync_if_r <= `NSC_CTRL_RST;
         avs_readdata_o <= 32'h0;
      end else if (ce_i) begin
         ack_r <= req & ~ack_r;
         if (avs_write_i && ack_r && avs_address_i == `NSC_REG_CTRL) begin
            sync_if_r <= avs_writedata_i[`NSC_CTRL_SYNC];
         end
         if (avs_read_i && !ack_r) begin
            avs_readdata_o <= 32'h0;
            unique case (avs_address_i)
               `NSC_REG_CTRL: avs_readdata_o[`NSC_CTRL_SYNC] <= sync_if_r;
               `NSC_REG_STATE: begin
                  avs_readdata_o[`NSC_STATE_DIE +: DIE_W] <= die_r;
                  avs_readdata_o[`NSC_STATE_MODE +: 3] <= mode_r;
                  avs_readdata_o[`NSC_STATE_CMD +: 8] <= cmd_r;
               end
               `NSC_REG_COLUMN: avs_readdata_o[COL_W-1:0] <= column_o;
               default: avs_readdata_o <= 32'h0;
            endcase
         end
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_plain_status: assert property (cmd_stb && dq_s == `NSC_OP_STATUS
      |=> mode_r == nsc_pkg::NSC_MODE_STATUS && !per_plane_r)
      else $error("plain status did not enter status mode");
   a_enh_blocked: assert property (cmd_stb && dq_s == `NSC_OP_ENH && !enh_ok
      |=> st_r == nsc_pkg::NSC_ST_CMD)
      else $error("enhanced status taken during reset or otp");
   a_fixed_die: assert property (addr_stb && st_r == nsc_pkg::NSC_ST_FIX
      |=> die_r == $past(dq_s[`NSC_DIE_BIT]) && mode_r == nsc_pkg::NSC_MODE_STATUS)
      else $error("fixed status selected wrong die");
   a_chcol_busy: assert property (cmd_stb && dq_s == `NSC_OP_CHCOL && !sel_rdy
      |=> st_r != nsc_pkg::NSC_ST_COL)
      else $error("column change accepted while busy");
   a_confirm_data: assert property (cmd_stb && dq_s == `NSC_OP_CONFIRM
      && st_r == nsc_pkg::NSC_ST_CONF |=> mode_r == nsc_pkg::NSC_MODE_DATA
      && col_r == $past(col_tmp_r))
      else $error("confirm did not start data output");
   a_sync_align: assert property (sync_if_r |-> column_o[0] == 1'h0)
      else $error("odd column in synchronous mode");
   a_die_onehot: assert property ($onehot0(die_en_o)
      && (mode_r != nsc_pkg::NSC_MODE_IDLE || die_en_o == '0))
      else $error("more than one die enabled");
   a_status_byte: assert property (re_fall && mode_r == nsc_pkg::NSC_MODE_STATUS
      && !cmd_stb && !addr_stb |=> !nand_dq_oe_n_o
      && nand_dq_o[`NSC_SR_RDY] == $past(die_rdy_i[die_r]))
      else $error("status byte not driven");
   a_bus_wait: assert property (req && avs_waitrequest_o && ce_i
      ##1 $stable(req) && req |-> !avs_waitrequest_o)
      else $error("slave waited more than one cycle");
endmodule : nsc_top
`default_nettype wire

// file: verification/nsc_host_model.sv
// host controller model: nand command, address and read cycles
// assumes the bench resolves the dq wire and feeds it back on bus_i
`default_nettype none
module nsc_host_model (
   input wire logic clk_i,
   input wire logic [7:0] bus_i,
   output logic cle_o,
   output logic ale_o,
   output logic we_n_o,
   output logic re_n_o,
   output logic [7:0] dq_o,
   output logic drive_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cle_o = 1'b0;
      ale_o = 1'b0;
      we_n_o = 1'b1;
      re_n_o = 1'b1;
      dq_o = 8'h00;
      drive_o = 1'b0;
   end
   // ----------------------------------------
   // cycle tasks
   // ----------------------------------------
   task automatic phase();
      repeat (4) @(posedge clk_i);
   endtask : phase
   // one latched cycle; the bench picks 78h before 05h on die 1
   task automatic put(input logic cmd, input logic [7:0] b);
      cle_o <= cmd;
      ale_o <= !cmd;
      dq_o <= b;
      drive_o <= 1'b1;
      we_n_o <= 1'b0;
      phase();
      we_n_o <= 1'b1;
      phase();
      cle_o <= 1'b0;
      ale_o <= 1'b0;
      drive_o <= 1'b0;
      dq_o <= ~b; // released bus shows the inverse
      phase();
   endtask : put
   // read strobe; waits after each cycle cover the column setup time
   task automatic rd(output logic [7:0] b);
      re_n_o <= 1'b0;
      repeat (8) @(posedge clk_i);
      b = bus_i;
      re_n_o <= 1'b1;
      phase();
      phase();
   endtask : rd
endmodule : nsc_host_model
`default_nettype wire

// file: verification/test_nsc_top.sv
// self-checking bench of the status and read-column decoder
// assumes nsc_top with default parameters and nsc_host_model on the pins
`default_nettype none
module test_nsc_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1;
   logic [3:0] avs_address_i = 4'h0;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic nand_cle_i, nand_ale_i, nand_we_n_i, nand_re_n_i, host_drv;
   logic [7:0] host_dq, nand_dq_o;
   wire logic [7:0] nand_dq_i;
   logic nand_dq_oe_n_o;
   logic [1:0] die_rdy_i = 2'h0;
   logic [1:0] die_array_ready_flag_i = 2'h0;
   logic [7:0] die_fail_i = 8'h00;
   logic [7:0] die_previous_op_error_i = 8'h00;
   logic [3:0] plane_act_i = 4'h0;
   logic por_busy_i = 1'b0;
   logic otp_mode_i = 1'b0;
   logic [7:0] cache_data_i = 8'h00;
   logic cache_rd_o;
   logic [15:0] column_o;
   logic [1:0] die_en_o;
   int bad_count = 0;
   int checks = 0;
   int rd_pulses = 0;
   int seed = 34;
   logic [31:0] r;
   logic [7:0] b;
   logic [15:0] col;
   int d, e, p;
   always #2.5 clk_i = ~clk_i;
   assign nand_dq_i = host_drv ? host_dq : (!nand_dq_oe_n_o ? nand_dq_o : host_dq);
   always @(posedge clk_i) begin
      if (cache_rd_o === 1'b1) begin
         rd_pulses++;
      end
   end
   nsc_top nsc_top_inst (.clk_i, .rst_i, .ce_i, .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .nand_cle_i, .nand_ale_i,
      .nand_we_n_i, .nand_re_n_i, .nand_dq_i, .nand_dq_o, .nand_dq_oe_n_o, .die_rdy_i,
      .die_array_ready_flag_i, .die_fail_i, .die_previous_op_error_i, .plane_act_i, .por_busy_i, .otp_mode_i,
      .cache_data_i, .cache_rd_o, .column_o, .die_en_o);
   nsc_host_model nsc_host_model_inst (.clk_i(clk_i), .bus_i(nand_dq_i), .cle_o(nand_cle_i),
      .ale_o(nand_ale_i), .we_n_o(nand_we_n_i), .re_n_o(nand_re_n_i), .dq_o(host_dq),
      .drive_o(host_drv));
   // ----------------------------------------
   // checking and bus tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic test_done();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done
   task automatic av(input logic w, input logic [3:0] a, input logic [31:0] wd,
         output logic [31:0] rd);
      int n;
      n = 0;
      avs_address_i <= a;
      avs_writedata_i <= wd;
      avs_write_i <= w;
      avs_read_i <= !w;
      do begin
         @(posedge clk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 50);
      if (n >= 50) begin
         bad_count++;
         test_done();
      end
      rd = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      @(posedge clk_i);
   endtask : av
   task automatic cmd(input logic [7:0] op);
      nsc_host_model_inst.put(1'b1, op);
   endtask : cmd
   task automatic adr(input logic [7:0] a);
      nsc_host_model_inst.put(1'b0, a);
   endtask : adr
   // status byte of die dd: fail bits of plane pp, or ored over active planes
   function automatic logic [7:0] exp_st(int dd, int pp, bit enh);
      logic [7:0] s;
      s = 8'h00;
      s[6] = die_rdy_i[dd];
      s[5] = die_array_ready_flag_i[dd];
      s[1] = enh ? die_previous_op_error_i[dd*4+pp] : |(die_previous_op_error_i[dd*4+:4] & plane_act_i);
      s[0] = enh ? die_fail_i[dd*4+pp] : |(die_fail_i[dd*4+:4] & plane_act_i);
      return s;
   endfunction : exp_st
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      repeat (60000) @(posedge clk_i);
      bad_count++;
      test_done();
   end
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk(nand_dq_oe_n_o, 1);
      chk(die_en_o, 0);
      av(1'b0, 4'h0, 32'h0, r);
      chk(r, 0);
      av(1'b0, 4'h4, 32'h0, r);
      chk(r[6:4], 1);
      av(1'b1, 4'hC, 32'hFFFF_FFFF, r);
      av(1'b0, 4'hC, 32'h0, r);
      chk(r, 0);
      $display("reset test done");
      for (int i = 0; i < 8; i++) begin
         d = i % 2;
         e = 1 - d;
         p = $unsigned($random(seed)) % 4;
         die_rdy_i <= 2'($random(seed));
         die_array_ready_flag_i <= 2'($random(seed));
         die_fail_i <= 8'($random(seed));
         die_previous_op_error_i <= 8'($random(seed));
         plane_act_i <= 4'($random(seed));
         por_busy_i <= i[1];
         otp_mode_i <= i[2];
         cmd(8'h71);
         adr({7'($random(seed)), d[0]});
         nsc_host_model_inst.rd(b);
         chk(b, exp_st(d, p, 0));
         chk(die_en_o, 2'b01 << d);
         cmd(8'h70);
         nsc_host_model_inst.rd(b);
         chk(b, exp_st(d, p, 0));
         chk(b, exp_st(d, p, 0));
         por_busy_i <= 1'b0;
         otp_mode_i <= 1'b0;
         cmd(8'h78);
         adr(8'($random(seed)));
         adr({6'h00, 2'(p)});
         adr({7'h00, e[0]});
         nsc_host_model_inst.rd(b);
         chk(b, exp_st(e, p, 1));
         chk(die_en_o, 2'b01 << e);
         por_busy_i <= i[0];
         otp_mode_i <= !i[0];
         cmd(8'h78);
         adr(8'h00);
         adr(8'h00);
         adr({7'h00, d[0]});
         chk(die_en_o, 2'b01 << e);
         nsc_host_model_inst.rd(b);
         chk(b, exp_st(e, p, 1));
         por_busy_i <= 1'b0;
         otp_mode_i <= 1'b0;
         for (int q = 0; q < 4; q++) begin
            cmd(8'h78);
            adr(8'h00);
            adr({6'h00, 2'(q)});
            adr({7'h00, d[0]});
            nsc_host_model_inst.rd(b);
            chk(b, exp_st(d, q, 1));
         end
      end
      $display("status test done");
      for (int m = 0; m < 2; m++) begin
         av(1'b1, 4'h0, 32'(m), r);
         die_rdy_i <= 2'b11;
         die_array_ready_flag_i <= m ? 2'b00 : 2'b11;
         cache_data_i <= 8'($random(seed));
         cmd(8'h78);
         adr(8'h00);
         adr(8'h00);
         adr(8'h01);
         av(1'b0, 4'h4, 32'h0, r);
         chk({r[6:4], r[0]}, 4'h5);
         cmd(8'h00);
         av(1'b0, 4'h4, 32'h0, r);
         chk(r[6:4], 4);
         cmd(8'h05);
         adr(8'h23);
         adr(8'h01);
         cmd(8'hE0);
         col = m ? 16'h0122 : 16'h0123;
         chk(column_o, col);
         nsc_host_model_inst.rd(b);
         chk(b, cache_data_i);
         chk(rd_pulses, m + 1);
         col = col + (m ? 16'h2 : 16'h1);
         chk(column_o, col);
         av(1'b0, 4'h8, 32'h0, r);
         chk(r[15:0], col);
         die_rdy_i <= 2'b00;
         cmd(8'h05);
         adr(8'h40);
         adr(8'h00);
         cmd(8'hE0);
         chk(column_o, col);
      end
      $display("column test done");
      test_done();
   end
endmodule : test_nsc_top
`default_nettype wire
